// file: rtl/dpm_pkg.sv
// Constants shared by the priority map register bank and its decoder.
package dpm_pkg;
	localparam int          DPM_MAP_BITS   = 64;
	localparam int          DPM_NUM_BYTES  = 8;
	localparam int          DPM_CODE_BITS  = 6;
	localparam int          DPM_ADDR_BITS  = 8;
	// Byte offsets of the map, most significant byte first.
	localparam logic [7:0]  DPM_OFS_BYTE7  = 8'h60;
	localparam logic [7:0]  DPM_OFS_BYTE6  = 8'h61;
	localparam logic [7:0]  DPM_OFS_BYTE5  = 8'h62;
	localparam logic [7:0]  DPM_OFS_BYTE4  = 8'h63;
	localparam logic [7:0]  DPM_OFS_BYTE3  = 8'h64;
	localparam logic [7:0]  DPM_OFS_BYTE2  = 8'h65;
	localparam logic [7:0]  DPM_OFS_BYTE1  = 8'h66;
	localparam logic [7:0]  DPM_OFS_BYTE0  = 8'h67;
	localparam logic [7:0]  DPM_BYTE_RST   = 8'h00;
	localparam logic [7:0]  DPM_UNMAPPED   = 8'h00;
	// Code point field within the type-of-service byte.
	localparam int          DPM_TOS_MSB    = 7;
	localparam int          DPM_TOS_LSB    = 2;
endpackage

// file: rtl/dpm_code_decode.sv
// Full one-hot decoder for the six-bit code point.
`timescale 1ns/1ns
module dpm_code_decode
	import dpm_pkg::*;
#(
	parameter int CODE_BITS = DPM_CODE_BITS
) (
	// Code point in, one-hot selection out
	input  wire logic [CODE_BITS-1:0]      code,
	output logic      [(1<<CODE_BITS)-1:0] onehot
);
	always_comb begin
		onehot       = '0;
		onehot[code] = 1'b1;
	end
endmodule

// file: rtl/dpm_diffserv_priority_map.sv
// Programmable code point bitmap and per-frame priority classifier.
`timescale 1ns/1ns
// Notes on behaviour
// - The top six type-of-service bits decode one-hot into 64 code points.
// - A set map bit at the selected code point marks the frame high priority.
// - A clear map bit at the selected code point marks the frame low priority.
// - Offsets 0x60 to 0x65 hold map bits 63:56 down to 23:16.
// - Every map byte is read/write and resets to zero, so all low.
// - Offsets 0x66 and 0x67 hold bits 15:8 and 7:0, read/write, reset zero.
module dpm_diffserv_priority_map
	import dpm_pkg::*;
#(
	parameter int NUM_BYTES = DPM_NUM_BYTES
) (
	// Clock and reset
	input  wire logic                     mclk,
	input  wire logic                     arst_n,
	// Register access port
	input  wire logic [DPM_ADDR_BITS-1:0] reg_addr,
	input  wire logic                     reg_wr,
	input  wire logic [7:0]               reg_wdata,
	input  wire logic                     reg_rd,
	output logic      [7:0]               reg_rdata,
	output logic                          reg_rvalid,
	// Received frame header
	input  wire logic                     frm_valid,
	input  wire logic [7:0]               frm_tos,
	// Classification result
	output logic                          prio_valid,
	output logic                          prio_high
);
	logic [7:0]              map_reg   [NUM_BYTES];
	logic [7:0]              map_next  [NUM_BYTES];
	logic [7:0]              rdata_reg;
	logic [7:0]              rdata_next;
	logic                    rvalid_reg;
	logic                    rvalid_next;
	logic                    pvalid_reg;
	logic                    pvalid_next;
	logic                    phigh_reg;
	logic                    phigh_next;
	logic [DPM_MAP_BITS-1:0] map_bits;
	logic [DPM_MAP_BITS-1:0] code_sel;
	logic [DPM_CODE_BITS-1:0] code;
	logic                    wr_hit    [NUM_BYTES];
	logic [7:0]              byte_ofs  [NUM_BYTES];

	// Index 0 is the most significant byte at the lowest offset.
	assign byte_ofs[0] = DPM_OFS_BYTE7;
	assign byte_ofs[1] = DPM_OFS_BYTE6;
	assign byte_ofs[2] = DPM_OFS_BYTE5;
	assign byte_ofs[3] = DPM_OFS_BYTE4;
	assign byte_ofs[4] = DPM_OFS_BYTE3;
	assign byte_ofs[5] = DPM_OFS_BYTE2;
	assign byte_ofs[6] = DPM_OFS_BYTE1;
	assign byte_ofs[7] = DPM_OFS_BYTE0;

	always_comb begin
		for (int i = 0; i < NUM_BYTES; i++) begin
			map_bits[DPM_MAP_BITS-1-8*i -: 8] = map_reg[i];
		end
	end

	assign code = frm_tos[DPM_TOS_MSB:DPM_TOS_LSB];

	dpm_code_decode #(
		.CODE_BITS (DPM_CODE_BITS)
	) u_decode (
		.code   (code),
		.onehot (code_sel)
	);

	always_comb begin
		for (int i = 0; i < NUM_BYTES; i++) begin
			wr_hit[i]   = reg_wr && (reg_addr == byte_ofs[i]);
			map_next[i] = wr_hit[i] ? reg_wdata : map_reg[i];
		end
	end

	always_comb begin
		rdata_next  = DPM_UNMAPPED;
		rvalid_next = reg_rd;
		for (int i = 0; i < NUM_BYTES; i++) begin
			if (reg_rd && reg_addr == byte_ofs[i]) begin
				rdata_next = map_reg[i];
			end
		end
		if (!reg_rd) begin
			rdata_next = rdata_reg;
		end
	end

	always_comb begin
		pvalid_next = frm_valid;
		phigh_next  = phigh_reg;
		if (frm_valid) begin
			phigh_next = |(code_sel & map_bits);
		end
	end

	// A write landing with a frame takes effect from the next frame on.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < NUM_BYTES; i++) begin
				map_reg[i] <= DPM_BYTE_RST;
			end
			rdata_reg  <= DPM_UNMAPPED;
			rvalid_reg <= 1'b0;
			pvalid_reg <= 1'b0;
			phigh_reg  <= 1'b0;
		end else begin
			for (int i = 0; i < NUM_BYTES; i++) begin
				map_reg[i] <= map_next[i];
			end
			rdata_reg  <= rdata_next;
			rvalid_reg <= rvalid_next;
			pvalid_reg <= pvalid_next;
			phigh_reg  <= phigh_next;
		end
	end

	assign reg_rdata  = rdata_reg;
	assign reg_rvalid = rvalid_reg;
	assign prio_valid = pvalid_reg;
	assign prio_high  = phigh_reg;

	// Helper: map bit chosen by the frame, sampled at the frame cycle.
	logic sel_bit;
	assign sel_bit = map_bits[code];

	sequence s_frame_set;
		frm_valid && sel_bit;
	endsequence

	sequence s_frame_clr;
		frm_valid && !sel_bit;
	endsequence

	property p_onehot;
		@(posedge mclk) disable iff (!arst_n)
		$onehot(code_sel) && code_sel[code];
	endproperty
	a_onehot: assert property (p_onehot)
		else $error("code point decode is not one-hot");

	property p_high;
		@(posedge mclk) disable iff (!arst_n)
		s_frame_set |=> prio_valid && prio_high;
	endproperty
	a_high: assert property (p_high)
		else $error("set map bit did not give high priority");

	property p_low;
		@(posedge mclk) disable iff (!arst_n)
		s_frame_clr |=> prio_valid && !prio_high;
	endproperty
	a_low: assert property (p_low)
		else $error("clear map bit did not give low priority");

	property p_top_byte;
		@(posedge mclk) disable iff (!arst_n)
		reg_wr && reg_addr == DPM_OFS_BYTE7 ##1 reg_rd && !reg_wr
			&& reg_addr == DPM_OFS_BYTE7
		|=> reg_rvalid && reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_top_byte: assert property (p_top_byte)
		else $error("top map byte did not read back its write");

	property p_reset_zero;
		@(posedge mclk)
		$rose(arst_n) |-> map_bits == '0;
	endproperty
	a_reset_zero: assert property (p_reset_zero)
		else $error("map not all zero after reset");

	property p_low_byte;
		@(posedge mclk) disable iff (!arst_n)
		reg_wr && reg_addr == DPM_OFS_BYTE0
		|=> map_bits[7:0] == $past(reg_wdata);
	endproperty
	a_low_byte: assert property (p_low_byte)
		else $error("lowest map byte not at its offset");

	property p_one_result;
		@(posedge mclk) disable iff (!arst_n)
		prio_valid |-> $past(frm_valid);
	endproperty
	a_one_result: assert property (p_one_result)
		else $error("result without a frame");

	// Offsets outside the map window must neither store nor return data.
	logic addr_outside;
	assign addr_outside = (reg_addr < DPM_OFS_BYTE7) ||
		(reg_addr > DPM_OFS_BYTE0);

	sequence s_rd_outside;
		reg_rd && addr_outside;
	endsequence

	sequence s_wr_outside;
		reg_wr && addr_outside;
	endsequence

	property p_rd_answer;
		@(posedge mclk) disable iff (!arst_n)
		reg_rd |=> reg_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read strobe not answered one cycle later");

	property p_rd_outside;
		@(posedge mclk) disable iff (!arst_n)
		s_rd_outside |=> reg_rvalid && reg_rdata == DPM_UNMAPPED;
	endproperty
	a_rd_outside: assert property (p_rd_outside)
		else $error("read outside the map returned data");

	property p_wr_outside;
		@(posedge mclk) disable iff (!arst_n)
		s_wr_outside |=> $stable(map_bits);
	endproperty
	a_wr_outside: assert property (p_wr_outside)
		else $error("write outside the map changed the map");

	property p_hold;
		@(posedge mclk) disable iff (!arst_n)
		!frm_valid |=> !prio_valid && $stable(prio_high);
	endproperty
	a_hold: assert property (p_hold)
		else $error("result changed without a frame");
endmodule

// file: test/testbench.sv
// Self-checking bench for the priority map register bank and classifier.
`timescale 1ns/1ns
module testbench;
	import dpm_pkg::*;
	logic        mclk = 1'b0;
	logic        arst_n = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic        reg_wr = 1'b0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic        reg_rvalid;
	logic        frm_valid = 1'b0;
	logic [7:0]  frm_tos = 8'h00;
	logic        prio_valid;
	logic        prio_high;
	logic [63:0] map_m = 64'h0;
	logic [7:0]  rq[$];
	logic        pq[$];
	int          fails = 0;
	int          total_checks = 0;
	int          cyc = 0;

	always #5 mclk = ~mclk;

	dpm_diffserv_priority_map uut (.mclk(mclk), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.frm_valid(frm_valid), .frm_tos(frm_tos),
		.prio_valid(prio_valid), .prio_high(prio_high));

	task automatic print_verdict;
		if (fails == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic cmp(input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: exp %h got %h", $time, exp, got);
		end
	endtask

	// Strobes change only once per falling edge, so back to back is safe.
	task automatic step(input logic w, input logic r, input logic f);
		@(negedge mclk);
		reg_wr = w;
		reg_rd = r;
		frm_valid = f;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		step(1'b1, 1'b0, 1'b0);
		reg_addr = a;
		reg_wdata = d;
		if (a >= 8'h60 && a <= 8'h67)
			map_m[8*(8'h67-a) +: 8] = d;
	endtask

	task automatic rd(input logic [7:0] a);
		step(1'b0, 1'b1, 1'b0);
		reg_addr = a;
		rq.push_back((a >= 8'h60 && a <= 8'h67) ?
			map_m[8*(8'h67-a) +: 8] : DPM_UNMAPPED);
	endtask

	task automatic frm(input logic [7:0] t);
		step(1'b0, 1'b0, 1'b1);
		frm_tos = t;
		pq.push_back(map_m[t[7:2]]);
	endtask

	task automatic rd_all;
		for (int a = 8'h60; a <= 8'h68; a++)
			rd(8'(a));
	endtask

	// Results are matched in order against the oldest expectation.
	always @(posedge mclk) begin
		#1;
		if (reg_rvalid === 1'b1)
			cmp(rq.size() ? rq.pop_front() : 8'hxx, reg_rdata);
		if (prio_valid === 1'b1)
			cmp({7'h0, pq.size() ? pq.pop_front() : 1'bx},
				{7'h0, prio_high});
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			print_verdict();
		end
	end

	initial begin
		void'($urandom(32'ha766_786c));
		repeat (16) @(negedge mclk);
		arst_n = 1'b1;
		rd_all();
		for (int p = 0; p < 2; p++) begin
			for (int a = 8'h60; a <= 8'h67; a++)
				wr(8'(a), p ? ~map_m[8*(8'h67-a) +: 8] : 8'($urandom));
			wr(8'h68, 8'($urandom));
			rd_all();
			for (int n = 0; n < 64; n++)
				frm({6'(n), 2'($urandom)});
		end
		step(1'b0, 1'b0, 1'b0);
		repeat (3) @(negedge mclk);
		arst_n = 1'b0;
		map_m = 64'h0;
		repeat (2) @(negedge mclk);
		arst_n = 1'b1;
		rd_all();
		frm(8'hfc);
		// A write read straight back, then a frame on the top code point.
		wr(8'h60, 8'h80);
		rd(8'h60);
		frm(8'hfc);
		step(1'b0, 1'b0, 1'b0);
		repeat (3) @(negedge mclk);
		if (rq.size() != 0 || pq.size() != 0)
			fails++;
		print_verdict();
	end
endmodule
